// >>> tmr_regs.v
// Purpose: register access, compare, capture and flags of a 16-bit timer
// Assumes: single clock, Avalon-MM slave with waitrequest, one byte per word
// Notes: answers every access in the cycle after it is raised
//
// Function
// - counter read and written through high latch
// - one high latch shared by all 16-bit registers
// - counter write blocks next timer-tick match
// - compare registers continuously matched against counter
// - compare writes commit both bytes together
// - capture event copies counter into capture register
// - capture register can be counter upper limit
// - capture reads use shared high latch
// - enables: capture 5, A 4, B 3, overflow 2
// - request needs enable, global enable and flag
// - capture flag on event, or top when limit
// - match A flag set tick after match
// - match B flag set tick after match
// - force strobe leaves match flags unchanged
// - overflow flag per mode, max in normal, clear-on-match
// - flags clear by vector ack or write-one
// - PWM overflow at bottom or top; normal at max
// - capture limit disconnects capture pin
//
// Implementation choices: the address map and register access over Avalon-MM.
`include "tmr_consts.vh"

module tmr_regs (
	input wire clk_sys_i,
	input wire rst_n_i,
	input wire [3:0] avs_address_i,
	input wire avs_read_i,
	input wire avs_write_i,
	input wire [31:0] avs_writedata_i,
	output reg [31:0] avs_readdata_o,
	output reg avs_waitrequest_o,
	input wire global_irq_enable_i,
	input wire capture_input_pin_i,
	input wire comparator_out_i,
	output reg capture_irq_o,
	output reg match_a_irq_o,
	output reg match_b_irq_o,
	output reg overflow_irq_o,
	output reg match_a_o,
	output reg match_b_o,
	output reg force_match_a_strobe_o,
	output reg force_match_b_strobe_o
);

	// ***************************************************************
	// state
	// ***************************************************************
	reg [15:0] counter_value; // live count
	reg [15:0] compare_value_a; // compare A
	reg [15:0] compare_value_b; // compare B
	reg [15:0] captured_value; // capture / top
	reg [7:0] high_latch; // shared temporary high byte
	reg [7:0] timer_irq_mask; // enables
	reg [7:0] timer_irq_flags; // sticky flags
	reg [3:0] waveform_mode_field; // counting mode
	reg [2:0] clock_select; // prescaler choice
	reg edge_rising; // capture edge select
	reg cap_src_comp; // capture from comparator
	reg count_up; // direction in phase-correct modes
	reg block_match; // match blocked on next tick
	reg [9:0] prescale; // prescaler counter
	reg cap_s1, cap_s2, cap_s3; // pin synchroniser and history
	reg cmp_s1, cmp_s2, cmp_s3; // comparator synchroniser
	reg ma_hit, mb_hit; // matches seen on last tick
	reg serving; // access being answered

	// ***************************************************************
	// decode helpers
	// ***************************************************************
	// top value for a mode
	function [15:0] top_of;
		input [3:0] m;
		input [15:0] ocra;
		input [15:0] icr;
		begin
			case (m)
				4'h1, 4'h5: top_of = `TMR_TOP8;
				4'h2, 4'h6: top_of = `TMR_TOP9;
				4'h3, 4'h7: top_of = `TMR_TOP10;
				4'h4, 4'h9, 4'hb, 4'hf: top_of = ocra;
				4'h8, 4'ha, 4'hc, 4'he: top_of = icr;
				default: top_of = `TMR_MAX;
			endcase
		end
	endfunction

	// mode uses capture register as top
	function icr_top;
		input [3:0] m;
		begin
			icr_top = (m == 4'h8) || (m == 4'ha) || (m == 4'hc) || (m == 4'he);
		end
	endfunction

	wire [15:0] top = top_of(waveform_mode_field, compare_value_a, captured_value);
	wire phase_mode = (waveform_mode_field[3:2] == 2'b00 && waveform_mode_field != 4'h0)
		|| (waveform_mode_field[3:2] == 2'b10);
	wire fast_mode = (waveform_mode_field == 4'h5) || (waveform_mode_field == 4'h6)
		|| (waveform_mode_field == 4'h7) || (waveform_mode_field == 4'he)
		|| (waveform_mode_field == 4'hf);
	wire clear_on_match_mode = (waveform_mode_field == 4'h4)
		|| (waveform_mode_field == 4'hc);
	wire cap_limit = icr_top(waveform_mode_field);

	// ***************************************************************
	// timer tick from the prescaler
	// ***************************************************************
	reg tick;
	always @* begin
		case (clock_select)
			3'h1: tick = 1'b1;
			3'h2: tick = (prescale[2:0] == 3'h7);
			3'h3: tick = (prescale[5:0] == 6'h3f);
			3'h4: tick = (prescale[7:0] == 8'hff);
			3'h5: tick = (prescale == 10'h3ff);
			default: tick = 1'b0; // stopped, external clock not wired here
		endcase
	end

	// ***************************************************************
	// bus decode
	// ***************************************************************
	wire acc = (avs_read_i | avs_write_i) & ~serving; // take once, answer next cycle
	wire wr = avs_write_i & acc;
	wire rd = avs_read_i & acc;
	wire [7:0] wbyte = avs_writedata_i[7:0];
	wire [15:0] wword = {high_latch, wbyte};

	// capture event: synchronised pin or comparator, chosen edge
	wire src_now = cap_src_comp ? cmp_s2 : cap_s2;
	wire src_old = cap_src_comp ? cmp_s3 : cap_s3;
	wire cap_evt = ~cap_limit && (edge_rising ? (src_now & ~src_old)
		: (~src_now & src_old));

	// count stage
	wire at_top = (counter_value == top);
	wire at_bot = (counter_value == `TMR_RST_WORD);
	wire ma_now = (counter_value == compare_value_a);
	wire mb_now = (counter_value == compare_value_b);

	// overflow event per mode
	wire ovf_evt = tick && (phase_mode ? (at_bot && !count_up)
		: fast_mode ? at_top
		: (counter_value == `TMR_MAX));
	wire cap_top_evt = tick && cap_limit && at_top;

	// software clears: write-one or vector acknowledge
	wire [7:0] clr_w1 = (wr && avs_address_i == `TMR_IDX_FLAGS) ? wbyte : 8'h00;
	wire [7:0] clr_ack = (wr && avs_address_i == `TMR_IDX_IACK) ? wbyte : 8'h00;
	wire [7:0] clr = (clr_w1 | clr_ack) & `TMR_FLAG_MASK;

	// ***************************************************************
	// prescaler, synchronisers
	// ***************************************************************
	always @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			prescale <= 10'h000;
			cap_s1 <= 1'b0;
			cap_s2 <= 1'b0;
			cap_s3 <= 1'b0;
			cmp_s1 <= 1'b0;
			cmp_s2 <= 1'b0;
			cmp_s3 <= 1'b0;
		end else begin
			prescale <= prescale + 10'h001;
			cap_s1 <= capture_input_pin_i;
			cap_s2 <= cap_s1;
			cap_s3 <= cap_s2;
			cmp_s1 <= comparator_out_i;
			cmp_s2 <= cmp_s1;
			cmp_s3 <= cmp_s2;
		end
	end

	// ***************************************************************
	// counter, compare, capture and latch
	// ***************************************************************
	always @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			counter_value <= `TMR_RST_WORD;
			compare_value_a <= `TMR_RST_WORD;
			compare_value_b <= `TMR_RST_WORD;
			captured_value <= `TMR_RST_WORD;
			high_latch <= `TMR_RST_BYTE;
			count_up <= 1'b1;
			block_match <= 1'b0;
			ma_hit <= 1'b0;
			mb_hit <= 1'b0;
		end else begin
			// matches on this tick, unless blocked by a counter write
			if (tick) begin
				ma_hit <= ma_now & ~block_match;
				mb_hit <= mb_now & ~block_match;
				block_match <= 1'b0;
			end else begin
				ma_hit <= 1'b0;
				mb_hit <= 1'b0;
			end
			// counting
			if (tick) begin
				if (phase_mode) begin
					if (count_up && at_top) begin
						count_up <= 1'b0;
						counter_value <= counter_value - 16'h0001;
					end else if (!count_up && at_bot) begin
						count_up <= 1'b1;
						counter_value <= counter_value + 16'h0001;
					end else if (count_up) begin
						counter_value <= counter_value + 16'h0001;
					end else begin
						counter_value <= counter_value - 16'h0001;
					end
				end else if ((clear_on_match_mode || fast_mode) && at_top) begin
					counter_value <= `TMR_RST_WORD;
				end else begin
					counter_value <= counter_value + 16'h0001;
				end
			end
			// capture copy
			if (cap_evt)
				captured_value <= counter_value;
			// register writes: low byte commits latch and byte together
			if (wr) begin
				case (avs_address_i)
					`TMR_IDX_CNT_HI, `TMR_IDX_CMPA_HI, `TMR_IDX_CMPB_HI,
					`TMR_IDX_CAP_HI: begin
						high_latch <= wbyte;
					end
					`TMR_IDX_CNT_LO: begin
						counter_value <= wword; // write wins over count
						block_match <= 1'b1;
					end
					`TMR_IDX_CMPA_LO: compare_value_a <= wword;
					`TMR_IDX_CMPB_LO: compare_value_b <= wword;
					`TMR_IDX_CAP_LO: captured_value <= wword; // top setting
					default: ;
				endcase
			end
			// counter and capture low-byte reads latch the high byte
			if (rd && avs_address_i == `TMR_IDX_CNT_LO)
				high_latch <= counter_value[15:8];
			if (rd && avs_address_i == `TMR_IDX_CAP_LO)
				high_latch <= captured_value[15:8];
		end
	end

	// ***************************************************************
	// control, mask and flags
	// ***************************************************************
	always @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			timer_irq_mask <= `TMR_RST_BYTE;
			timer_irq_flags <= `TMR_RST_BYTE;
			waveform_mode_field <= 4'h0;
			clock_select <= 3'h0;
			edge_rising <= 1'b0;
			cap_src_comp <= 1'b0;
			force_match_a_strobe_o <= 1'b0;
			force_match_b_strobe_o <= 1'b0;
		end else begin
			force_match_a_strobe_o <= 1'b0;
			force_match_b_strobe_o <= 1'b0;
			if (wr && avs_address_i == `TMR_IDX_MASK)
				timer_irq_mask <= wbyte & `TMR_FLAG_MASK;
			if (wr && avs_address_i == `TMR_IDX_CTRL) begin
				waveform_mode_field <= avs_writedata_i[`TMR_CTRL_WGM_LSB +: 4];
				clock_select <= avs_writedata_i[`TMR_CTRL_CS_LSB +: 3];
				edge_rising <= avs_writedata_i[`TMR_CTRL_EDGE];
				cap_src_comp <= avs_writedata_i[`TMR_CTRL_ACSEL];
				// strobes act only in non-PWM modes, never touch flags
				force_match_a_strobe_o <= avs_writedata_i[`TMR_CTRL_FOCA]
					& ~(phase_mode | fast_mode);
				force_match_b_strobe_o <= avs_writedata_i[`TMR_CTRL_FOCB]
					& ~(phase_mode | fast_mode);
			end
			// set wins over clear in the same cycle
			timer_irq_flags[`TMR_BIT_CAP] <= (cap_evt | cap_top_evt)
				| (timer_irq_flags[`TMR_BIT_CAP] & ~clr[`TMR_BIT_CAP]);
			timer_irq_flags[`TMR_BIT_MA] <= ma_hit
				| (timer_irq_flags[`TMR_BIT_MA] & ~clr[`TMR_BIT_MA]);
			timer_irq_flags[`TMR_BIT_MB] <= mb_hit
				| (timer_irq_flags[`TMR_BIT_MB] & ~clr[`TMR_BIT_MB]);
			timer_irq_flags[`TMR_BIT_OVF] <= ovf_evt
				| (timer_irq_flags[`TMR_BIT_OVF] & ~clr[`TMR_BIT_OVF]);
		end
	end

	// ***************************************************************
	// interrupt requests and match outputs
	// ***************************************************************
	always @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			capture_irq_o <= 1'b0;
			match_a_irq_o <= 1'b0;
			match_b_irq_o <= 1'b0;
			overflow_irq_o <= 1'b0;
			match_a_o <= 1'b0;
			match_b_o <= 1'b0;
		end else begin
			// request = enable & global enable & flag
			capture_irq_o <= global_irq_enable_i & timer_irq_mask[`TMR_BIT_CAP]
				& timer_irq_flags[`TMR_BIT_CAP];
			match_a_irq_o <= global_irq_enable_i & timer_irq_mask[`TMR_BIT_MA]
				& timer_irq_flags[`TMR_BIT_MA];
			match_b_irq_o <= global_irq_enable_i & timer_irq_mask[`TMR_BIT_MB]
				& timer_irq_flags[`TMR_BIT_MB];
			overflow_irq_o <= global_irq_enable_i & timer_irq_mask[`TMR_BIT_OVF]
				& timer_irq_flags[`TMR_BIT_OVF];
			// match pulses for the waveform generator
			match_a_o <= tick & ma_now & ~block_match;
			match_b_o <= tick & mb_now & ~block_match;
		end
	end

	// ***************************************************************
	// Avalon slave answer
	// ***************************************************************
	reg [7:0] rbyte;
	always @* begin
		case (avs_address_i)
			`TMR_IDX_CNT_LO: rbyte = counter_value[7:0];
			`TMR_IDX_CMPA_LO: rbyte = compare_value_a[7:0];
			`TMR_IDX_CMPA_HI: rbyte = compare_value_a[15:8];
			`TMR_IDX_CMPB_LO: rbyte = compare_value_b[7:0];
			`TMR_IDX_CMPB_HI: rbyte = compare_value_b[15:8];
			`TMR_IDX_CAP_LO: rbyte = captured_value[7:0];
			`TMR_IDX_CNT_HI, `TMR_IDX_CAP_HI: rbyte = high_latch;
			`TMR_IDX_MASK: rbyte = timer_irq_mask;
			`TMR_IDX_FLAGS: rbyte = timer_irq_flags;
			`TMR_IDX_CTRL: rbyte = {edge_rising, clock_select, waveform_mode_field};
			default: rbyte = 8'h00; // unmapped reads zero
		endcase
	end

	// wait one cycle, then release with data
	always @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			serving <= 1'b0;
			avs_waitrequest_o <= 1'b1;
			avs_readdata_o <= 32'h00000000;
		end else begin
			serving <= acc;
			avs_waitrequest_o <= ~acc;
			if (rd)
				avs_readdata_o <= {23'h000000, (avs_address_i == `TMR_IDX_CTRL) ?
					cap_src_comp : 1'b0, rbyte};
		end
	end

endmodule

// >>> tmr_consts.vh
// Purpose: constants of the 16-bit timer register block
// Assumes: word-indexed Avalon-MM register map, one byte per word
// Notes: offsets are word indices; byte address is four times the index
`ifndef TMR_CONSTS_VH
`define TMR_CONSTS_VH

// ***************************************************************
// register indices
// ***************************************************************
`define TMR_IDX_CNT_LO 4'h0
`define TMR_IDX_CNT_HI 4'h1
`define TMR_IDX_CMPA_LO 4'h2
`define TMR_IDX_CMPA_HI 4'h3
`define TMR_IDX_CMPB_LO 4'h4
`define TMR_IDX_CMPB_HI 4'h5
`define TMR_IDX_CAP_LO 4'h6
`define TMR_IDX_CAP_HI 4'h7
`define TMR_IDX_MASK 4'h8
`define TMR_IDX_FLAGS 4'h9
`define TMR_IDX_CTRL 4'ha
`define TMR_IDX_IACK 4'hb

// ***************************************************************
// bit positions in mask and flag registers
// ***************************************************************
`define TMR_BIT_CAP 5
`define TMR_BIT_MA 4
`define TMR_BIT_MB 3
`define TMR_BIT_OVF 2
`define TMR_FLAG_MASK 8'h3c

// ***************************************************************
// control register fields
// ***************************************************************
`define TMR_CTRL_WGM_LSB 0
`define TMR_CTRL_CS_LSB 4
`define TMR_CTRL_EDGE 7
`define TMR_CTRL_ACSEL 8
`define TMR_CTRL_FOCA 9
`define TMR_CTRL_FOCB 10

// ***************************************************************
// reset values and fixed tops
// ***************************************************************
`define TMR_RST_BYTE 8'h00
`define TMR_RST_WORD 16'h0000
`define TMR_MAX 16'hffff
`define TMR_TOP8 16'h00ff
`define TMR_TOP9 16'h01ff
`define TMR_TOP10 16'h03ff

`endif

// >>> tmr_regs_chk.sv
// Purpose: port-level checker of the timer register block
// Assumes: one clock domain, synchronous active-low reset
// Notes: attached by bind at the foot of this file
`include "tmr_consts.vh"

module tmr_regs_chk (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic [3:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [31:0] avs_readdata_o,
	input wire logic avs_waitrequest_o,
	input wire logic global_irq_enable_i,
	input wire logic capture_input_pin_i,
	input wire logic comparator_out_i,
	input wire logic capture_irq_o,
	input wire logic match_a_irq_o,
	input wire logic match_b_irq_o,
	input wire logic overflow_irq_o,
	input wire logic match_a_o,
	input wire logic match_b_o,
	input wire logic force_match_a_strobe_o,
	input wire logic force_match_b_strobe_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// ***************************************************************
	// bus handshake
	// ***************************************************************
	default clocking @(posedge clk_sys_i);
	endclocking
	default disable iff (!rst_n_i);
	// answer lasts one cycle only
	property p_wait_pulse;
		!avs_waitrequest_o |=> avs_waitrequest_o;
	endproperty
	a_wait_pulse: assert property (p_wait_pulse) else $error("answer held too long");
	// read answered one cycle after it is raised
	property p_read_answer;
		$rose(avs_read_i) |=> !avs_waitrequest_o;
	endproperty
	a_read_answer: assert property (p_read_answer) else $error("read not answered");
	// write answered one cycle after it is raised
	property p_write_answer;
		$rose(avs_write_i) |=> !avs_waitrequest_o && avs_write_i;
	endproperty
	a_write_answer: assert property (p_write_answer) else $error("write not answered");
	// read data only moves after a read
	property p_data_hold;
		$changed(avs_readdata_o) |-> $past(avs_read_i);
	endproperty
	a_data_hold: assert property (p_data_hold) else $error("read data moved alone");
	// ***************************************************************
	// interrupts, matches, strobes
	// ***************************************************************
	// no request once global enable has been off for two cycles
	property p_irq_gate;
		!global_irq_enable_i [*2] |->
			!(capture_irq_o || match_a_irq_o || match_b_irq_o || overflow_irq_o);
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("request without enable");
	// write-one to the flag drops the request
	property p_irq_clear;
		avs_write_i && !avs_waitrequest_o && avs_address_i == `TMR_IDX_FLAGS
			&& avs_writedata_i[`TMR_BIT_MA] |-> ##[0:2] !match_a_irq_o;
	endproperty
	a_irq_clear: assert property (p_irq_clear) else $error("request not cleared");
	// a match is a single tick pulse
	property p_match_pulse;
		match_a_o |=> !match_a_o;
	endproperty
	a_match_pulse: assert property (p_match_pulse) else $error("match pulse too long");
	// force strobes are single pulses
	property p_force_pulse;
		force_match_a_strobe_o || force_match_b_strobe_o
			|=> !(force_match_a_strobe_o || force_match_b_strobe_o);
	endproperty
	a_force_pulse: assert property (p_force_pulse) else $error("strobe too long");
	// main scenarios reached
	c_match_a: cover property (match_a_o);
	c_cap_irq: cover property (capture_irq_o);
	c_ovf_irq: cover property (overflow_irq_o);
endmodule

bind tmr_regs tmr_regs_chk tmr_regs_chk_i (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
	.avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
	.avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
	.avs_waitrequest_o(avs_waitrequest_o), .global_irq_enable_i(global_irq_enable_i),
	.capture_input_pin_i(capture_input_pin_i), .comparator_out_i(comparator_out_i),
	.capture_irq_o(capture_irq_o), .match_a_irq_o(match_a_irq_o),
	.match_b_irq_o(match_b_irq_o), .overflow_irq_o(overflow_irq_o), .match_a_o(match_a_o),
	.match_b_o(match_b_o), .force_match_a_strobe_o(force_match_a_strobe_o),
	.force_match_b_strobe_o(force_match_b_strobe_o));

// >>> tmr_regs_bench.sv
// Purpose: self-checking bench of the timer register block
// Assumes: a stopped timer holds its count; bus answers after one cycle
// Notes: inputs change by non-blocking assignment at rising edges
`include "tmr_consts.vh"

module tmr_regs_bench;
	timeunit 1ns;
	timeprecision 1ps;
	// ***************************************************************
	// signals
	// ***************************************************************
	logic clk = 1'b0; // 20 MHz clock
	logic rst_n = 1'b0; // reset, active low
	logic [3:0] adr = 4'h0; // word index
	logic rd = 1'b0; // read request
	logic wr = 1'b0; // write request
	logic [31:0] wd = 32'h00000000; // write data
	logic gie = 1'b0; // global irq enable
	logic cpin = 1'b0; // capture pin
	logic cmpo = 1'b0; // comparator output
	wire [31:0] rdat;
	wire wreq;
	wire [3:0] irq; // capture, a, b, overflow
	wire [3:0] pulse; // match a, match b, force a, force b
	logic [7:0] ma_cnt = 8'h00; // match a pulses seen
	logic [7:0] mb_cnt = 8'h00; // match b pulses seen
	logic [7:0] fa_cnt = 8'h00; // force a pulses seen
	logic [7:0] fb_cnt = 8'h00; // force b pulses seen
	int error_cnt = 0;
	int tests_run = 0;
	logic [7:0] q; // last byte read
	// clock
	always #25 clk = ~clk;
	// count the single-cycle outputs of the block
	always @(posedge clk) begin
		if (pulse[3] === 1'b1)
			ma_cnt <= ma_cnt + 8'h01;
		if (pulse[2] === 1'b1)
			mb_cnt <= mb_cnt + 8'h01;
		if (pulse[1] === 1'b1)
			fa_cnt <= fa_cnt + 8'h01;
		if (pulse[0] === 1'b1)
			fb_cnt <= fb_cnt + 8'h01;
	end
	tmr_regs tmr_regs_i (.clk_sys_i(clk), .rst_n_i(rst_n), .avs_address_i(adr),
		.avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_readdata_o(rdat),
		.avs_waitrequest_o(wreq), .global_irq_enable_i(gie), .capture_input_pin_i(cpin),
		.comparator_out_i(cmpo), .capture_irq_o(irq[3]), .match_a_irq_o(irq[2]),
		.match_b_irq_o(irq[1]), .overflow_irq_o(irq[0]), .match_a_o(pulse[3]),
		.match_b_o(pulse[2]), .force_match_a_strobe_o(pulse[1]),
		.force_match_b_strobe_o(pulse[0]));
	// ***************************************************************
	// tasks
	// ***************************************************************
	// verdict and end of run
	task print_verdict;
		if (error_cnt == 0 && tests_run > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// byte compare
	task chk8(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: byte %h, want %h", $time, got, exp);
		end
	endtask
	// bit compare
	task chk1(input logic got, input logic exp);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: bit %b, want %b", $time, got, exp);
		end
	endtask
	// one bus cycle, held until waitrequest low
	task bus(input logic w, input logic [3:0] a, input logic [15:0] d);
		int n;
		n = 0;
		@(posedge clk);
		adr <= a;
		rd <= !w;
		wr <= w;
		wd <= {16'h0000, d};
		do begin
			@(posedge clk);
			n++;
		end while (wreq !== 1'b0 && n < 20);
		q = rdat[7:0];
		rd <= 1'b0;
		wr <= 1'b0;
		if (wreq !== 1'b0) begin
			error_cnt++;
			$display("wrong value at %0t: no answer", $time);
			print_verdict();
		end
	endtask
	task wr8(input logic [3:0] a, input logic [15:0] d);
		bus(1'b1, a, d);
	endtask
	task rd8(input logic [3:0] a, input logic [7:0] e);
		bus(1'b0, a, 16'h0000);
		chk8(q, e);
	endtask
	// high byte into latch, low byte commits
	task w16(input logic [3:0] lo, input logic [15:0] v);
		wr8(lo + 4'h1, {8'h00, v[15:8]});
		wr8(lo, {8'h00, v[7:0]});
	endtask
	// low byte latches high byte
	task r16(input logic [3:0] lo, input logic [15:0] e);
		rd8(lo, e[7:0]);
		rd8(lo + 4'h1, e[15:8]);
	endtask
	// poll the flag register until a bit sets
	task wait_flag(input int b);
		int n;
		n = 0;
		do begin
			bus(1'b0, `TMR_IDX_FLAGS, 16'h0000);
			n++;
		end while (q[b] !== 1'b1 && n < 200);
		chk1(q[b], 1'b1);
		if (q[b] !== 1'b1)
			print_verdict();
	endtask
	// ***************************************************************
	// main sequence
	// ***************************************************************
	initial begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		rd8(`TMR_IDX_MASK, 8'h00);
		rd8(`TMR_IDX_FLAGS, 8'h00);
		rd8(4'hc, 8'h00);
		wr8(`TMR_IDX_MASK, 16'h00ff);
		rd8(`TMR_IDX_MASK, 8'h3c);
		w16(`TMR_IDX_CMPA_LO, 16'h1234);
		r16(`TMR_IDX_CMPA_LO, 16'h1234);
		w16(`TMR_IDX_CMPB_LO, 16'h0040);
		r16(`TMR_IDX_CMPB_LO, 16'h0040);
		w16(`TMR_IDX_CNT_LO, 16'habcd);
		r16(`TMR_IDX_CNT_LO, 16'habcd);
		// a capture read between the two halves reloads the latch
		wr8(`TMR_IDX_CNT_HI, 16'h0077);
		rd8(`TMR_IDX_CAP_LO, 8'h00);
		wr8(`TMR_IDX_CNT_LO, 16'h0030);
		r16(`TMR_IDX_CNT_LO, 16'h0030);
		// rising capture edge on a stopped counter
		wr8(`TMR_IDX_CTRL, 16'h0080);
		@(posedge clk);
		cpin <= 1'b1;
		wait_flag(`TMR_BIT_CAP);
		r16(`TMR_IDX_CAP_LO, 16'h0030);
		chk1(irq[3], 1'b0);
		gie <= 1'b1;
		repeat (2) @(posedge clk);
		chk1(irq[3], 1'b1);
		wr8(`TMR_IDX_FLAGS, 16'h0020);
		rd8(`TMR_IDX_FLAGS, 8'h00);
		chk1(irq[3], 1'b0);
		// counter written equal to compare a: that match is lost
		w16(`TMR_IDX_CMPA_LO, 16'h0030);
		w16(`TMR_IDX_CNT_LO, 16'h0030);
		wr8(`TMR_IDX_CTRL, 16'h0010);
		repeat (30) @(posedge clk);
		rd8(`TMR_IDX_FLAGS, 8'h08);
		chk1(irq[1], 1'b1);
		chk1(irq[2], 1'b0);
		chk8(ma_cnt, 8'h00);
		chk8(mb_cnt, 8'h01);
		wr8(`TMR_IDX_IACK, 16'h0008);
		rd8(`TMR_IDX_FLAGS, 8'h00);
		// real match on compare a
		wr8(`TMR_IDX_CTRL, 16'h0000);
		w16(`TMR_IDX_CMPA_LO, 16'h0100);
		wr8(`TMR_IDX_CTRL, 16'h0010);
		wait_flag(`TMR_BIT_MA);
		chk8(ma_cnt, 8'h01);
		chk1(irq[2], 1'b1);
		// overflow at max in normal mode
		wr8(`TMR_IDX_CTRL, 16'h0000);
		w16(`TMR_IDX_CNT_LO, 16'hfff0);
		wr8(`TMR_IDX_CTRL, 16'h0010);
		wait_flag(`TMR_BIT_OVF);
		chk1(irq[0], 1'b1);
		// fast 8-bit mode on the /8 tick: overflow at top
		wr8(`TMR_IDX_CTRL, 16'h0000);
		wr8(`TMR_IDX_FLAGS, 16'h003c);
		w16(`TMR_IDX_CNT_LO, 16'h00f0);
		wr8(`TMR_IDX_CTRL, 16'h0025);
		wait_flag(`TMR_BIT_OVF);
		// phase-correct 8-bit mode: no overflow at top, only at bottom
		wr8(`TMR_IDX_CTRL, 16'h0000);
		wr8(`TMR_IDX_FLAGS, 16'h003c);
		w16(`TMR_IDX_CNT_LO, 16'h00fc);
		wr8(`TMR_IDX_CTRL, 16'h0011);
		repeat (20) @(posedge clk);
		rd8(`TMR_IDX_FLAGS, 8'h00);
		wait_flag(`TMR_BIT_OVF);
		// both force strobes leave flags alone
		wr8(`TMR_IDX_CTRL, 16'h0000);
		wr8(`TMR_IDX_FLAGS, 16'h003c);
		wr8(`TMR_IDX_CTRL, 16'h0600);
		rd8(`TMR_IDX_FLAGS, 8'h00);
		chk8(fa_cnt, 8'h01);
		chk8(fb_cnt, 8'h01);
		// capture register as top: pin ignored
		w16(`TMR_IDX_CNT_LO, 16'h0555);
		wr8(`TMR_IDX_CTRL, 16'h008c);
		@(posedge clk);
		cpin <= 1'b0;
		repeat (4) @(posedge clk);
		cpin <= 1'b1;
		repeat (4) @(posedge clk);
		r16(`TMR_IDX_CAP_LO, 16'h0030);
		rd8(`TMR_IDX_FLAGS, 8'h00);
		// comparator as capture source, rising edge, counter stopped
		wr8(`TMR_IDX_CTRL, 16'h0180);
		@(posedge clk);
		cmpo <= 1'b1;
		wait_flag(`TMR_BIT_CAP);
		r16(`TMR_IDX_CAP_LO, 16'h0555);
		wr8(`TMR_IDX_FLAGS, 16'h0020);
		// counter reaching capture top sets capture flag
		w16(`TMR_IDX_CAP_LO, 16'h0010);
		w16(`TMR_IDX_CNT_LO, 16'h0000);
		wr8(`TMR_IDX_CTRL, 16'h001c);
		wait_flag(`TMR_BIT_CAP);
		print_verdict();
	end
endmodule
